// ---- sim/tb_dram_channel_config_regs.sv ----
// self-checking bench for the channel config register bank
// assumes the single-cycle register port; inputs move on falling edges
module tb_dram_channel_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import dram_channel_cfg_pkg::*;

  logic        clk_sys_i = 1'b0;
  logic        reset_i   = 1'b1;
  logic        wr_q      = 1'b0;
  logic        rd_q      = 1'b0;
  logic [11:0] addr      = 12'h000;
  logic [31:0] wdata     = 32'h0;
  logic        act       = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  amc;
  logic        csel;
  logic        icf;
  logic [2:0]  msf;
  logic        core533;
  logic        route;
  logic        cke;
  logic [31:0] p [9];
  logic [7:0]  attr_out;
  logic [7:0]  clkdis_out;
  logic [15:0] bank_out;
  logic [15:0] mode1_out;
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [11:0] offs [9] = '{OFF_CH1_RANK23_ATTR, OFF_CH1_CLOCK_DIS,
    OFF_CH1_BANK_ARCH, OFF_CH1_TIMING_0, OFF_CH1_TIMING_1, OFF_CH1_TIMING_2,
    OFF_CH1_CTRL_MODE_0, OFF_CH1_CTRL_MODE_1, OFF_CH1_CTRL_MODE_2};
  logic [31:0] rsts [9] = '{32'(RST_CH1_RANK23_ATTR), 32'(RST_CH1_CLOCK_DIS),
    32'(RST_CH1_BANK_ARCH), RST_CH1_TIMING_0, RST_CH1_TIMING_1,
    RST_CH1_TIMING_2, RST_CH1_CTRL_MODE_0, 32'(RST_CH1_CTRL_MODE_1),
    RST_CH1_CTRL_MODE_2};
  int          wid [9] = '{8, 8, 16, 32, 32, 32, 32, 16, 32};

  always #5 clk_sys_i = ~clk_sys_i;

  dram_channel_config_regs u_dram_channel_config_regs (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_wr_i(wr_q),
    .reg_rd_i(rd_q), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .ch1_io_activate_i(act), .reg_rdata_o(rdata),
    .addressing_mode_ctrl_o(amc), .single_channel_selector_o(csel),
    .init_complete_o(icf), .mode_select_field_o(msf),
    .core_clock_533_o(core533), .ch1_route_en_o(route), .ch1_cke_o(cke),
    .ch1_rank23_attribute_o(attr_out), .ch1_clock_disable_o(clkdis_out),
    .ch1_bank_architecture_o(bank_out), .ch1_timing_0_o(p[3]),
    .ch1_timing_1_o(p[4]), .ch1_timing_2_o(p[5]),
    .ch1_controller_mode_0_o(p[6]), .ch1_controller_mode_1_o(mode1_out),
    .ch1_controller_mode_2_o(p[8]));
  // narrow outputs widened whole so each element has a single driver
  assign p[0] = {24'h0, attr_out};
  assign p[1] = {24'h0, clkdis_out};
  assign p[2] = {16'h0, bank_out};
  assign p[7] = {16'h0, mode1_out};

  // mode 11 never routes; selector 1 in single mode routes channel 1
  function automatic logic exp_route(input logic [1:0] m, input logic s);
    return (m == 2'h1) || (m == 2'h2) || ((m == 2'h0) && s);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // strobe for one edge, then one idle edge so strobes never merge
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    wr_q = 1'b1; addr = a; wdata = d;
    @(negedge clk_sys_i);
    wr_q = 1'b0;
    @(negedge clk_sys_i);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    rd_q = 1'b1; addr = a;
    @(negedge clk_sys_i);
    rd_q = 1'b0;
    d = rdata;
    @(negedge clk_sys_i);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [31:0] v;
    void'($urandom(32'hfb387828));
    repeat (2) @(negedge clk_sys_i);
    reset_i = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(offs[i], d); chk(d, rsts[i]);
    end
    rd(OFF_CHANNEL_CONTROL, d); chk(d, RST_CHANNEL_CONTROL);
    rd(OFF_CLOCKING_CONFIG, d); chk(d, RST_CLOCKING_CONFIG);
    $display("test reset_values done");
    for (int i = 0; i < 9; i++) begin
      v = $urandom();
      if (wid[i] < 32) v = v & ((32'h1 << wid[i]) - 32'h1);
      wr(offs[i], v);
      rd(offs[i], d); chk(d, v);
      chk(p[i], v);
    end
    // write then read on the very next edge; read data lasts one cycle
    v = $urandom();
    wr_q = 1'b1;
    addr = OFF_CH1_TIMING_0;
    wdata = v;
    @(negedge clk_sys_i);
    wr_q = 1'b0;
    rd_q = 1'b1;
    @(negedge clk_sys_i);
    rd_q = 1'b0;
    chk(rdata, v);
    @(negedge clk_sys_i);
    chk(rdata, 32'h0);
    $display("test mirror_regs done");
    // every mode, selector and activate pairing; last quarter mode off
    for (int k = 0; k < 16; k++) begin
      v = $urandom();
      v[1:0] = 2'(k);
      v[2] = k[2];
      if (k >= 12) v[18:16] = 3'h0;
      act = k[3];
      wr(OFF_CHANNEL_CONTROL, v);
      rd(OFF_CHANNEL_CONTROL, d); chk(d, v & CC_WMASK);
      chk({25'h0, icf, msf, csel, amc}, {25'h0, v[19:16], v[2:0]});
      chk(32'(route), 32'(exp_route(v[1:0], v[2])));
      chk(32'(cke), 32'(k[3] && (v[18:16] != 3'h0)));
    end
    // random programming that keeps to the legal encodings
    for (int k = 0; k < 8; k++) begin
      v = $urandom() & CC_WMASK;
      v[1:0] = 2'($urandom() % 3);
      v[2] = 1'b0;
      wr(OFF_CHANNEL_CONTROL, v);
      chk(32'(route), 32'(exp_route(v[1:0], v[2])));
    end
    act = 1'b1;
    wr(OFF_CHANNEL_CONTROL, 32'h00050001);
    chk(32'(cke), 32'h1);
    act = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    chk(32'(cke), 32'h0);
    $display("test channel_control done");
    for (int j = 0; j < 4; j++) begin
      v = $urandom();
      if (j < 2) v[16] = j[0];
      wr(OFF_CLOCKING_CONFIG, v);
      rd(OFF_CLOCKING_CONFIG, d); chk(d, v & CK_WMASK);
      chk(32'(core533), 32'(v[16]));
    end
    $display("test clocking_config done");
    wr(12'h204, $urandom());
    rd(12'h204, d); chk(d, 32'h0);
    rd(OFF_CHANNEL_CONTROL, d); chk(d, 32'h00050001);
    $display("test unmapped done");
    reset_i = 1'b1;
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    rd(OFF_CHANNEL_CONTROL, d); chk(d, RST_CHANNEL_CONTROL);
    rd(OFF_CH1_TIMING_0, d); chk(d, RST_CH1_TIMING_0);
    $display("test second_reset done");
    end_sim();
  end
endmodule

// ---- verilog/dram_channel_cfg_pkg.sv ----
// constants for the second-channel and channel-control register bank
// assumes a byte-offset register port driven by the memory-mapped window
// What this block does
// - channel control steers boundary decode and routing
// - mode field: single, dual asymmetric, dual symmetric
// - selector bit names populated channel when single
// - bit 19 init complete, read-write, reset zero
// - bits 18:16 mode select, read-write, reset zero
// - clocking bit 16 picks memory core clock
// - second-channel registers mirror first-channel behaviour
// - clock enable needs activate bit and nonzero mode
package dram_channel_cfg_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [11:0] OFF_CH1_RANK23_ATTR  = 12'h189;
  localparam logic [11:0] OFF_CH1_CLOCK_DIS    = 12'h18c;
  localparam logic [11:0] OFF_CH1_BANK_ARCH    = 12'h18e;
  localparam logic [11:0] OFF_CH1_TIMING_0     = 12'h190;
  localparam logic [11:0] OFF_CH1_TIMING_1     = 12'h194;
  localparam logic [11:0] OFF_CH1_TIMING_2     = 12'h198;
  localparam logic [11:0] OFF_CH1_CTRL_MODE_0  = 12'h1a0;
  localparam logic [11:0] OFF_CH1_CTRL_MODE_1  = 12'h1a4;
  localparam logic [11:0] OFF_CH1_CTRL_MODE_2  = 12'h1a8;
  localparam logic [11:0] OFF_CHANNEL_CONTROL  = 12'h200;
  localparam logic [11:0] OFF_CLOCKING_CONFIG  = 12'hc00;

  localparam logic [7:0]  RST_CH1_RANK23_ATTR = 8'h00;
  localparam logic [7:0]  RST_CH1_CLOCK_DIS   = 8'h00;
  localparam logic [15:0] RST_CH1_BANK_ARCH   = 16'h0000;
  localparam logic [31:0] RST_CH1_TIMING_0    = 32'ha96000e8;
  localparam logic [31:0] RST_CH1_TIMING_1    = 32'h00006111;
  localparam logic [31:0] RST_CH1_TIMING_2    = 32'h000003ff;
  localparam logic [31:0] RST_CH1_CTRL_MODE_0 = 32'h40002801;
  localparam logic [15:0] RST_CH1_CTRL_MODE_1 = 16'h0000;
  localparam logic [31:0] RST_CH1_CTRL_MODE_2 = 32'h00000000;
  localparam logic [31:0] RST_CHANNEL_CONTROL = 32'h00000000;
  localparam logic [31:0] RST_CLOCKING_CONFIG = 32'h00000000;

  // channel control fields
  localparam int CC_AMC_LSB  = 0;
  localparam int CC_SEL_BIT  = 2;
  localparam int CC_MS_LSB   = 16;
  localparam int CC_INIT_BIT = 19;
  localparam logic [31:0] CC_WMASK = 32'h000f0007;
  // clocking config: bit 16 core clock, 6:4 frequency select kept r/w
  localparam int CK_CORE_BIT = 16;
  localparam logic [31:0] CK_WMASK = 32'hfffffff0;
  localparam logic [2:0]  MODE_OFF = 3'h0;

  typedef enum logic [1:0] {
    AM_SINGLE     = 2'h0,
    AM_DUAL_ASYM  = 2'h1,
    AM_DUAL_SYM   = 2'h2,
    AM_RESERVED   = 2'h3
  } addr_mode_t;
endpackage

// ---- verilog/dram_channel_config_regs.sv ----
// second-channel config registers, channel control and clocking config
// assumes a single-cycle register port; reads answer the next cycle
module dram_channel_config_regs
(
  input  wire logic                                    clk_sys_i,
  input  wire logic                                    reset_i,
  input  wire logic                                    reg_wr_i,
  input  wire logic                                    reg_rd_i,
  input  wire logic [dram_channel_cfg_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [dram_channel_cfg_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                                    ch1_io_activate_i,
  output logic      [dram_channel_cfg_pkg::DATA_W-1:0] reg_rdata_o,
  output logic      [1:0]                              addressing_mode_ctrl_o,
  output logic                                         single_channel_selector_o,
  output logic                                         init_complete_o,
  output logic      [2:0]                              mode_select_field_o,
  output logic                                         core_clock_533_o,
  output logic                                         ch1_route_en_o,
  output logic                                         ch1_cke_o,
  output logic      [7:0]                              ch1_rank23_attribute_o,
  output logic      [7:0]                              ch1_clock_disable_o,
  output logic      [15:0]                             ch1_bank_architecture_o,
  output logic      [31:0]                             ch1_timing_0_o,
  output logic      [31:0]                             ch1_timing_1_o,
  output logic      [31:0]                             ch1_timing_2_o,
  output logic      [31:0]                             ch1_controller_mode_0_o,
  output logic      [15:0]                             ch1_controller_mode_1_o,
  output logic      [31:0]                             ch1_controller_mode_2_o
);
  import dram_channel_cfg_pkg::*;

  logic [7:0]  attr_q, attr_d, clkdis_q, clkdis_d;
  logic [15:0] bank_q, bank_d, mode1_q, mode1_d;
  logic [31:0] t0_q, t0_d, t1_q, t1_d, t2_q, t2_d;
  logic [31:0] mode0_q, mode0_d, mode2_q, mode2_d;
  logic [31:0] cc_q, cc_d, ck_q, ck_d;
  logic [31:0] rdata_d;
  logic        route_d, route_q, cke_d, cke_q;
  addr_mode_t  amode;

  // second-channel bank: plain storage, meaning lives in the controller
  always_comb begin
    attr_d   = attr_q;
    clkdis_d = clkdis_q;
    bank_d   = bank_q;
    t0_d     = t0_q;
    t1_d     = t1_q;
    t2_d     = t2_q;
    mode0_d  = mode0_q;
    mode1_d  = mode1_q;
    mode2_d  = mode2_q;
    cc_d     = cc_q;
    ck_d     = ck_q;
    if (reg_wr_i) begin
      if (reg_addr_i == OFF_CH1_RANK23_ATTR) begin
        attr_d = reg_wdata_i[7:0];
      end else if (reg_addr_i == OFF_CH1_CLOCK_DIS) begin
        clkdis_d = reg_wdata_i[7:0];
      end else if (reg_addr_i == OFF_CH1_BANK_ARCH) begin
        bank_d = reg_wdata_i[15:0];
      end else if (reg_addr_i == OFF_CH1_TIMING_0) begin
        t0_d = reg_wdata_i;
      end else if (reg_addr_i == OFF_CH1_TIMING_1) begin
        t1_d = reg_wdata_i;
      end else if (reg_addr_i == OFF_CH1_TIMING_2) begin
        t2_d = reg_wdata_i;
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_0) begin
        mode0_d = reg_wdata_i;
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_1) begin
        mode1_d = reg_wdata_i[15:0];
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_2) begin
        mode2_d = reg_wdata_i;
      end else if (reg_addr_i == OFF_CHANNEL_CONTROL) begin
        // reserved bits stay zero; encodings stored as written
        cc_d = reg_wdata_i & CC_WMASK;
      end else if (reg_addr_i == OFF_CLOCKING_CONFIG) begin
        ck_d = reg_wdata_i & CK_WMASK;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = '0;
    if (reg_rd_i) begin
      if (reg_addr_i == OFF_CH1_RANK23_ATTR) begin
        rdata_d = {24'h000000, attr_q};
      end else if (reg_addr_i == OFF_CH1_CLOCK_DIS) begin
        rdata_d = {24'h000000, clkdis_q};
      end else if (reg_addr_i == OFF_CH1_BANK_ARCH) begin
        rdata_d = {16'h0000, bank_q};
      end else if (reg_addr_i == OFF_CH1_TIMING_0) begin
        rdata_d = t0_q;
      end else if (reg_addr_i == OFF_CH1_TIMING_1) begin
        rdata_d = t1_q;
      end else if (reg_addr_i == OFF_CH1_TIMING_2) begin
        rdata_d = t2_q;
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_0) begin
        rdata_d = mode0_q;
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_1) begin
        rdata_d = {16'h0000, mode1_q};
      end else if (reg_addr_i == OFF_CH1_CTRL_MODE_2) begin
        rdata_d = mode2_q;
      end else if (reg_addr_i == OFF_CHANNEL_CONTROL) begin
        rdata_d = cc_q;
      end else if (reg_addr_i == OFF_CLOCKING_CONFIG) begin
        rdata_d = ck_q;
      end
    end
  end

  // routing and clock enable derived from stored control
  always_comb begin
    amode = addr_mode_t'(cc_q[CC_AMC_LSB +: 2]);
    // channel 1 carries traffic in either dual mode or when selected
    // as the only populated channel; reserved mode routes nowhere
    case (amode)
      AM_DUAL_ASYM: route_d = 1'b1;
      AM_DUAL_SYM:  route_d = 1'b1;
      AM_SINGLE:    route_d = cc_q[CC_SEL_BIT];
      default:      route_d = 1'b0;
    endcase
    // dropping activate alone forces cke low
    cke_d = ch1_io_activate_i &&
            (cc_q[CC_MS_LSB +: 3] != MODE_OFF);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      attr_q      <= RST_CH1_RANK23_ATTR;
      clkdis_q    <= RST_CH1_CLOCK_DIS;
      bank_q      <= RST_CH1_BANK_ARCH;
      t0_q        <= RST_CH1_TIMING_0;
      t1_q        <= RST_CH1_TIMING_1;
      t2_q        <= RST_CH1_TIMING_2;
      mode0_q     <= RST_CH1_CTRL_MODE_0;
      mode1_q     <= RST_CH1_CTRL_MODE_1;
      mode2_q     <= RST_CH1_CTRL_MODE_2;
      cc_q        <= RST_CHANNEL_CONTROL;
      ck_q        <= RST_CLOCKING_CONFIG;
      reg_rdata_o <= '0;
      route_q     <= 1'b0;
      cke_q       <= 1'b0;
    end else begin
      attr_q      <= attr_d;
      clkdis_q    <= clkdis_d;
      bank_q      <= bank_d;
      t0_q        <= t0_d;
      t1_q        <= t1_d;
      t2_q        <= t2_d;
      mode0_q     <= mode0_d;
      mode1_q     <= mode1_d;
      mode2_q     <= mode2_d;
      cc_q        <= cc_d;
      ck_q        <= ck_d;
      reg_rdata_o <= rdata_d;
      route_q     <= route_d;
      cke_q       <= cke_d;
    end
  end

  assign addressing_mode_ctrl_o    = cc_q[CC_AMC_LSB +: 2];
  assign single_channel_selector_o = cc_q[CC_SEL_BIT];
  assign init_complete_o           = cc_q[CC_INIT_BIT];
  assign mode_select_field_o       = cc_q[CC_MS_LSB +: 3];
  assign core_clock_533_o          = ck_q[CK_CORE_BIT];
  assign ch1_route_en_o            = route_q;
  assign ch1_cke_o                 = cke_q;
  assign ch1_rank23_attribute_o    = attr_q;
  assign ch1_clock_disable_o       = clkdis_q;
  assign ch1_bank_architecture_o   = bank_q;
  assign ch1_timing_0_o            = t0_q;
  assign ch1_timing_1_o            = t1_q;
  assign ch1_timing_2_o            = t2_q;
  assign ch1_controller_mode_0_o   = mode0_q;
  assign ch1_controller_mode_1_o   = mode1_q;
  assign ch1_controller_mode_2_o   = mode2_q;

  a_cke_needs_both: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ch1_cke_o |-> $past(ch1_io_activate_i) &&
      $past(cc_q[CC_MS_LSB +: 3]) != MODE_OFF)
    else $error("cke high without activate and mode");

  // the converse: both conditions must raise cke one edge later
  a_cke_rises: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    ch1_io_activate_i && mode_select_field_o != MODE_OFF |=> ch1_cke_o)
    else $error("cke not raised with activate and mode");

  a_cke_drop_fast: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !ch1_io_activate_i |=> !ch1_cke_o)
    else $error("cke not dropped after activate cleared");

  a_dual_routes: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    (cc_q[1:0] == AM_DUAL_SYM || cc_q[1:0] == AM_DUAL_ASYM)
      |=> ch1_route_en_o)
    else $error("dual mode must route channel 1");

  a_single_sel: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    cc_q[1:0] == AM_SINGLE |=> ch1_route_en_o == $past(cc_q[CC_SEL_BIT]))
    else $error("single mode routing wrong");

  a_cc_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CHANNEL_CONTROL |=>
      mode_select_field_o == $past(reg_wdata_i[18:16]) &&
      init_complete_o == $past(reg_wdata_i[19]) &&
      addressing_mode_ctrl_o == $past(reg_wdata_i[1:0]))
    else $error("channel control write lost");

  // reserved bits of channel control never read back as one
  a_cc_reserved: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == OFF_CHANNEL_CONTROL |=>
      (reg_rdata_o & ~CC_WMASK) == 32'h00000000)
    else $error("channel control reserved bits set");

  a_cc_hold: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !(reg_wr_i && reg_addr_i == OFF_CHANNEL_CONTROL) |=>
      $stable(init_complete_o) && $stable(mode_select_field_o) &&
      $stable(addressing_mode_ctrl_o) && $stable(single_channel_selector_o))
    else $error("channel control changed without a write");

  a_ic_reset: assert property (
    @(posedge clk_sys_i)
    reset_i |=> !init_complete_o && mode_select_field_o == MODE_OFF)
    else $error("control not cleared by reset");

  a_mirror_reset: assert property (
    @(posedge clk_sys_i)
    reset_i |=> ch1_timing_0_o == RST_CH1_TIMING_0 &&
      ch1_timing_1_o == RST_CH1_TIMING_1 &&
      ch1_timing_2_o == RST_CH1_TIMING_2 &&
      ch1_controller_mode_0_o == RST_CH1_CTRL_MODE_0 &&
      !ch1_route_en_o && !ch1_cke_o)
    else $error("mirror registers not at reset values");

  a_core_clock: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CLOCKING_CONFIG |=>
      core_clock_533_o == $past(reg_wdata_i[16]))
    else $error("core clock bit not written");

  a_ck_low_zero: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == OFF_CLOCKING_CONFIG |=>
      (reg_rdata_o & ~CK_WMASK) == 32'h00000000)
    else $error("clocking config low bits set");

  a_timing_rdback: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_TIMING_0 ##1
      reg_rd_i && reg_addr_i == OFF_CH1_TIMING_0 && !reg_wr_i
      |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("timing 0 readback mismatch");

  a_rdata_idle: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    !reg_rd_i |=> reg_rdata_o == 32'h00000000)
    else $error("read data not cleared between reads");

  // each mirror register takes its write on the next edge
  a_attr_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_RANK23_ATTR |=>
      ch1_rank23_attribute_o == $past(reg_wdata_i[7:0]))
    else $error("rank attribute write lost");

  a_clkdis_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_CLOCK_DIS |=>
      ch1_clock_disable_o == $past(reg_wdata_i[7:0]))
    else $error("clock disable write lost");

  a_bank_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_BANK_ARCH |=>
      ch1_bank_architecture_o == $past(reg_wdata_i[15:0]))
    else $error("bank architecture write lost");

  a_t0_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_TIMING_0 |=>
      ch1_timing_0_o == $past(reg_wdata_i))
    else $error("timing 0 write lost");

  a_t1_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_TIMING_1 |=>
      ch1_timing_1_o == $past(reg_wdata_i))
    else $error("timing 1 write lost");

  a_t2_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_TIMING_2 |=>
      ch1_timing_2_o == $past(reg_wdata_i))
    else $error("timing 2 write lost");

  a_mode0_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_CTRL_MODE_0 |=>
      ch1_controller_mode_0_o == $past(reg_wdata_i))
    else $error("controller mode 0 write lost");

  a_mode1_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_CTRL_MODE_1 |=>
      ch1_controller_mode_1_o == $past(reg_wdata_i[15:0]))
    else $error("controller mode 1 write lost");

  a_mode2_write: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFF_CH1_CTRL_MODE_2 |=>
      ch1_controller_mode_2_o == $past(reg_wdata_i))
    else $error("controller mode 2 write lost");

  a_mode_reserved: assert property (
    @(posedge clk_sys_i) disable iff (reset_i)
    cc_q[1:0] == AM_RESERVED |=> !ch1_route_en_o)
    else $error("reserved mode must not route");
endmodule
